/* rtl/pmrb_defines.vh */
// constants for the phy management register bank
// Summary of operation
// - eleven 16-bit internal registers; ten reachable, one held for factory use
// - reachable: standard 0-5 and vendor 16-19; address 20 reserved
// - writing one to bit 4 starts access; device clears it when finished
// - control bit 15 resets the phy and self-clears; control resets to 0x3000
// - control bits 14,13,12: loopback, 100 Mbps select, auto-negotiation enable
// - control bit 11 powers down; bit 10 disables the media interface
// - control bit 9 restarts auto-negotiation and self-clears when done
// - control bit 8 full duplex, bit 7 collision test; bits 6-0 reserved
// - status bits 15-11 fixed capabilities; status resets to 0x7809
// - status bit 6 reads zero; status bits 10-7 reserved
// - status bit 5 reads one once auto-negotiation acknowledge completes
// - status bit 4 latches high on vendor interrupt or partner remote fault
// - status bit 2 reports link, latched low so a loss stays visible
// - status bit 1 latches high on jabber, zero in normal operation
// - status bit 3 reads one (autoneg capable); bit 0 reads one (extended)
// - register 3 read-only: oui bits 15-10, part 9-4, revision 3-0
`ifndef PMRB_DEFINES_VH
`define PMRB_DEFINES_VH
`define PMRB_ACCESS_OFS      8'h1c
`define PMRB_START_BIT       4
`define PMRB_CMD_BIT         5
`define PMRB_ADDR_LSB        6
`define PMRB_ADDR_MSB        10
`define PMRB_DATA_LSB        16
`define PMRB_REG_CONTROL     5'h00
`define PMRB_REG_STATUS      5'h01
`define PMRB_REG_ID_HIGH     5'h02
`define PMRB_REG_ID_LOW      5'h03
`define PMRB_REG_ADV         5'h04
`define PMRB_REG_PARTNER     5'h05
`define PMRB_REG_VEND_FIRST  5'h10
`define PMRB_REG_VEND_LAST   5'h13
`define PMRB_CONTROL_RESET   16'h3000
`define PMRB_STATUS_RESET    16'h7809
`define PMRB_CTL_RESET_BIT   15
`define PMRB_CTL_RESTART_BIT 9
`define PMRB_CTL_WMASK       16'hff80
`define PMRB_STS_CAPS        5'h0f
`define PMRB_PHY_RESET_CYC   8'h10
`define PMRB_ACCESS_CYC      4'h4
`endif

/* rtl/pmrb_self_clear.v */
// self-clearing command bit with a timed completion
`timescale 1ns/1ps
module pmrb_self_clear (
   sys_clk,
   rst_n,
   set_req,
   busy,
   done_pulse
);
   input        sys_clk;
   input        rst_n;
   input        set_req;
   output       busy;
   output       done_pulse;
   wire         sys_clk;
   wire         rst_n;
   wire         set_req;
   wire         busy;
   reg          done_pulse;
   parameter [7:0] DURATION = 8'h10;
   reg          busy_ff;
   reg  [7:0]   cnt_ff;
   assign busy = busy_ff;
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         busy_ff    <= 1'b0;
         cnt_ff     <= 8'h00;
         done_pulse <= 1'b0;
      end else begin
         done_pulse <= 1'b0;
         if (set_req && !busy_ff) begin
            busy_ff <= 1'b1;
            cnt_ff  <= DURATION;
         end else if (busy_ff) begin
            if (cnt_ff == 8'h01) begin
               busy_ff    <= 1'b0;
               done_pulse <= 1'b1;
            end
            cnt_ff <= cnt_ff - 8'h01;
         end
      end
   end
endmodule // pmrb_self_clear

/* rtl/pmrb_latch_bit.v */
// latched status bit that refreshes to the live condition after a read
`timescale 1ns/1ps
module pmrb_latch_bit (
   sys_clk,
   rst_n,
   live,
   read_ack,
   value
);
   input        sys_clk;
   input        rst_n;
   input        live;
   input        read_ack;
   output       value;
   wire         sys_clk;
   wire         rst_n;
   wire         live;
   wire         read_ack;
   parameter    LATCH_HIGH = 1;
   parameter    RESET_VAL  = 0;
   reg          value;
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         value <= (RESET_VAL != 0);
      end else if (read_ack) begin
         value <= live;
      end else if (LATCH_HIGH != 0) begin
         value <= value | live;
      end else begin
         value <= value & live;
      end
   end
endmodule // pmrb_latch_bit

/* rtl/pmrb_phy_mgmt_register_bank.v */
// phy management register bank behind the indirect access register
`timescale 1ns/1ps
`include "pmrb_defines.vh"
module pmrb_phy_mgmt_register_bank (
   sys_clk,
   rst_n,
   reg_addr,
   reg_wr,
   reg_rd,
   reg_wdata,
   reg_rdata,
   autoneg_done,
   vendor_irq_detect,
   partner_remote_fault,
   link_live,
   jabber_live,
   vendor_rdata,
   vendor_wr,
   vendor_addr,
   vendor_wdata,
   adv_rdata,
   partner_rdata,
   phy_reset_active,
   loop_back_enable,
   speed_100_select,
   autoneg_enable,
   power_down,
   media_interface_disable,
   autoneg_restart,
   full_duplex_select,
   collision_test_enable
);
   input         sys_clk;
   input         rst_n;
   input  [7:0]  reg_addr;
   input         reg_wr;
   input         reg_rd;
   input  [31:0] reg_wdata;
   output [31:0] reg_rdata;
   input         autoneg_done;
   input         vendor_irq_detect;
   input         partner_remote_fault;
   input         link_live;
   input         jabber_live;
   input  [15:0] vendor_rdata;
   output        vendor_wr;
   output [1:0]  vendor_addr;
   output [15:0] vendor_wdata;
   input  [15:0] adv_rdata;
   input  [15:0] partner_rdata;
   output        phy_reset_active;
   output        loop_back_enable;
   output        speed_100_select;
   output        autoneg_enable;
   output        power_down;
   output        media_interface_disable;
   output        autoneg_restart;
   output        full_duplex_select;
   output        collision_test_enable;
   wire          sys_clk;
   wire          rst_n;
   wire   [7:0]  reg_addr;
   wire          reg_wr;
   wire          reg_rd;
   wire   [31:0] reg_wdata;
   wire          autoneg_done;
   wire          vendor_irq_detect;
   wire          partner_remote_fault;
   wire          link_live;
   wire          jabber_live;
   wire   [15:0] vendor_rdata;
   wire   [15:0] adv_rdata;
   wire   [15:0] partner_rdata;
   // output nets, each driven by one continuous assignment below
   wire   [31:0] reg_rdata;
   wire          vendor_wr;
   wire   [1:0]  vendor_addr;
   wire   [15:0] vendor_wdata;
   wire          phy_reset_active;
   wire          loop_back_enable;
   wire          speed_100_select;
   wire          autoneg_enable;
   wire          power_down;
   wire          media_interface_disable;
   wire          autoneg_restart;
   wire          full_duplex_select;
   wire          collision_test_enable;

   // identity fields: arbitrary neutral values
   parameter [15:0] ID_HIGH   = 16'h0123;
   parameter [5:0]  ID_OUI_LO = 6'h05;
   parameter [5:0]  ID_PART   = 6'h01;
   parameter [3:0]  ID_REV    = 4'h0;

   localparam [1:0] ST_IDLE = 2'b00;
   localparam [1:0] ST_BUSY = 2'b01;
   localparam [1:0] ST_DONE = 2'b10;

   reg    [1:0]  state_ff;
   reg    [1:0]  nxt_state;
   reg    [3:0]  wait_ff;
   reg           cmd_ff;
   reg    [4:0]  index_ff;
   reg    [15:0] word_ff;
   reg    [15:0] ctl_ff;
   reg           vendor_wr_ff;
   reg           status_rd_ff;
   reg    [15:0] rd_mux;
   wire          rst_busy;
   wire          restart_busy;
   wire          rst_set;
   wire          restart_set;
   wire          ctl_wr;
   wire          lat_fault;
   wire          lat_link;
   wire          lat_jab;
   wire   [15:0] status_word;

   // decode of the target index into the vendor range 16-19
   function is_vendor;
      input [4:0] idx;
      begin
         is_vendor = (idx >= `PMRB_REG_VEND_FIRST) && (idx <= `PMRB_REG_VEND_LAST);
      end
   endfunction

   wire host_sel   = (reg_addr == `PMRB_ACCESS_OFS);
   wire start_req  = host_sel && reg_wr && reg_wdata[`PMRB_START_BIT] && (state_ff == ST_IDLE);
   wire finish     = (state_ff == ST_BUSY) && (wait_ff == 4'h1);
   // read and write completions, one cycle each; reg_rd has no side effect
   // because the status refresh keys off the sequencer, not the host strobe
   wire rd_finish  = finish && !cmd_ff;
   wire wr_finish  = finish && cmd_ff;

   // access sequencer; start written while busy is ignored
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (start_req) begin
               nxt_state = ST_BUSY;
            end
         end
         ST_BUSY: begin
            if (finish) begin
               nxt_state = ST_DONE;
            end
         end
         ST_DONE: begin
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   always @(posedge sys_clk) begin
      if (!rst_n) begin
         state_ff <= ST_IDLE;
         wait_ff  <= 4'h0;
         cmd_ff   <= 1'b0;
         index_ff <= 5'h00;
         word_ff  <= 16'h0000;
      end else begin
         state_ff <= nxt_state;
         if (host_sel && reg_wr && state_ff == ST_IDLE) begin
            cmd_ff   <= reg_wdata[`PMRB_CMD_BIT];
            index_ff <= reg_wdata[`PMRB_ADDR_MSB:`PMRB_ADDR_LSB];
            word_ff  <= reg_wdata[31:`PMRB_DATA_LSB];
         end
         if (start_req) begin
            wait_ff <= `PMRB_ACCESS_CYC;
         end else if (state_ff == ST_BUSY) begin
            wait_ff <= wait_ff - 4'h1;
         end
         if (rd_finish) begin
            word_ff <= rd_mux;
         end
      end
   end

   // write completes on finish; control bits 15 and 9 launch timed actions
   assign ctl_wr      = wr_finish && (index_ff == `PMRB_REG_CONTROL);
   assign rst_set     = ctl_wr && word_ff[`PMRB_CTL_RESET_BIT];
   assign restart_set = ctl_wr && word_ff[`PMRB_CTL_RESTART_BIT];

   // both timers share one duration; a new access is not held off while one runs
   pmrb_self_clear #(.DURATION(`PMRB_PHY_RESET_CYC)) u_phy_reset (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .set_req    (rst_set),
      .busy       (rst_busy),
      .done_pulse ()
   );

   pmrb_self_clear #(.DURATION(`PMRB_PHY_RESET_CYC)) u_an_restart (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .set_req    (restart_set),
      .busy       (restart_busy),
      .done_pulse ()
   );

   always @(posedge sys_clk) begin
      if (!rst_n || rst_busy) begin
         ctl_ff <= `PMRB_CONTROL_RESET;
      end else if (ctl_wr) begin
         ctl_ff <= word_ff & `PMRB_CTL_WMASK;
      end
   end

   // a status read refreshes latched bits after the value is captured
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         status_rd_ff <= 1'b0;
         vendor_wr_ff <= 1'b0;
      end else begin
         status_rd_ff <= rd_finish && (index_ff == `PMRB_REG_STATUS);
         vendor_wr_ff <= wr_finish && is_vendor(index_ff);
      end
   end

   // the vendor interrupt and the partner remote fault set the same latched flag
   wire          fault_live = vendor_irq_detect | partner_remote_fault;

   pmrb_latch_bit #(.LATCH_HIGH(1), .RESET_VAL(0)) u_fault (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .live     (fault_live),
      .read_ack (status_rd_ff),
      .value    (lat_fault)
   );

   // link starts latched low, so the first status read after reset shows no link
   pmrb_latch_bit #(.LATCH_HIGH(0), .RESET_VAL(0)) u_link (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .live     (link_live),
      .read_ack (status_rd_ff),
      .value    (lat_link)
   );

   pmrb_latch_bit #(.LATCH_HIGH(1), .RESET_VAL(0)) u_jab (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .live     (jabber_live),
      .read_ack (status_rd_ff),
      .value    (lat_jab)
   );

   // fixed capability bits plus live and latched conditions
   assign status_word = {`PMRB_STS_CAPS,
                         4'h0, 1'b0,
                         autoneg_done,
                         lat_fault,
                         1'b1,
                         lat_link,
                         lat_jab,
                         1'b1};

   // bits 15 and 9 are stored but read back through the busy timers, so a
   // stale one never shows once its timer has run out
   wire   [15:0] ctl_view = {rst_busy, ctl_ff[14:10], restart_busy, ctl_ff[8:0]};

   // factory register and unmapped indices read zero
   always @* begin
      if (index_ff == `PMRB_REG_CONTROL) begin
         rd_mux = ctl_view;
      end else if (index_ff == `PMRB_REG_STATUS) begin
         rd_mux = status_word;
      end else if (index_ff == `PMRB_REG_ID_HIGH) begin
         rd_mux = ID_HIGH;
      end else if (index_ff == `PMRB_REG_ID_LOW) begin
         rd_mux = {ID_OUI_LO, ID_PART, ID_REV};
      end else if (index_ff == `PMRB_REG_ADV) begin
         rd_mux = adv_rdata;
      end else if (index_ff == `PMRB_REG_PARTNER) begin
         rd_mux = partner_rdata;
      end else if (is_vendor(index_ff)) begin
         rd_mux = vendor_rdata;
      end else begin
         rd_mux = 16'h0000;
      end
   end

   // start bit reads one until the sequencer is idle again
   wire          start_flag = (state_ff != ST_IDLE);
   assign reg_rdata = host_sel ?
                      {word_ff, 5'h00, index_ff, cmd_ff, start_flag, 4'h0} :
                      32'h0000_0000;

   assign vendor_wr              = vendor_wr_ff;
   assign vendor_addr            = index_ff[1:0];
   assign vendor_wdata           = word_ff;
   assign phy_reset_active       = rst_busy;
   assign loop_back_enable       = ctl_ff[14];
   assign speed_100_select       = ctl_ff[13];
   assign autoneg_enable         = ctl_ff[12];
   assign power_down             = ctl_ff[11];
   assign media_interface_disable = ctl_ff[10];
   assign autoneg_restart        = restart_busy;
   assign full_duplex_select     = ctl_ff[8];
   assign collision_test_enable  = ctl_ff[7];
endmodule // pmrb_phy_mgmt_register_bank

/* verif/pmrb_checker.sv */
// concurrent checks on the register bank ports
`timescale 1ns/1ps
module pmrb_checker (
   input logic        sys_clk,
   input logic        rst_n,
   input logic [7:0]  reg_addr,
   input logic        reg_wr,
   input logic [31:0] reg_wdata,
   input logic [31:0] reg_rdata,
   input logic        vendor_wr,
   input logic        phy_reset_active,
   input logic        autoneg_restart,
   input logic        speed_100_select,
   input logic        autoneg_enable,
   input logic        loop_back_enable
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire acc_sel = reg_wr && reg_addr == 8'h1c;
   sequence busy_run;
      reg_rdata[4] [*5] ##1 !reg_rdata[4];
   endsequence
   sequence vend_end;
      reg_rdata[4] ##1 (!reg_rdata[4] && !vendor_wr);
   endsequence
   // self-clearing bits stand for exactly sixteen cycles
   sequence held_16(sig);
      sig [*8] ##1 sig [*8] ##1 !sig;
   endsequence
   start_run_a: assert property (
      acc_sel && reg_wdata[4] && !reg_rdata[4] |=> busy_run) else $error("start bit timing");
   busy_refuse_a: assert property (
      acc_sel && reg_rdata[4] |=> $stable(reg_rdata[10:5])) else $error("busy write taken");
   off_addr_a: assert property (
      reg_addr != 8'h1c |-> reg_rdata == 32'h0) else $error("unselected offset reads data");
   pad_zero_a: assert property (
      reg_rdata[3:0] == 4'h0 && reg_rdata[15:11] == 5'h00) else $error("pad bits set");
   vend_pulse_a: assert property (
      vendor_wr |-> vend_end) else $error("vendor write strobe misplaced");
   rst_clear_a: assert property (
      $rose(phy_reset_active) |-> held_16(phy_reset_active))
      else $error("phy reset length");
   restart_clear_a: assert property (
      $rose(autoneg_restart) |-> held_16(autoneg_restart))
      else $error("restart length");
   reset_vals_a: assert property (
      $rose(rst_n) |-> speed_100_select && autoneg_enable && !loop_back_enable)
      else $error("control not at reset value");
   ctl_reload_a: assert property (
      phy_reset_active && $past(phy_reset_active) |->
      speed_100_select && autoneg_enable && !loop_back_enable) else $error("no reload");
endmodule // pmrb_checker

bind pmrb_phy_mgmt_register_bank pmrb_checker u_pmrb_checker (.*);

/* verif/pmrb_phy_mgmt_register_bank_bench.sv */
// self-checking bench for the phy management register bank
`timescale 1ns/1ps
module pmrb_phy_mgmt_register_bank_bench;
   // read polarity of the command bit is a bank choice: zero reads, one writes
   localparam   RD = 1'b0;
   // identity fields are overridden so expectations do not lean on the defaults
   localparam [15:0] ID_HI_TB   = 16'h4321;
   localparam [5:0]  ID_OUI_TB  = 6'h2a;
   localparam [5:0]  ID_PART_TB = 6'h15;
   localparam [3:0]  ID_REV_TB  = 4'h9;
   logic        sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic        autoneg_done = 1'b0, vendor_irq_detect = 1'b0, partner_remote_fault = 1'b0;
   logic        link_live = 1'b0, jabber_live = 1'b0;
   logic [7:0]  reg_addr = 8'h1c;
   logic [31:0] reg_wdata = 32'h0;
   logic [15:0] vendor_rdata = 16'h1234, adv_rdata = 16'h05e1, partner_rdata = 16'h0041;
   wire  [31:0] reg_rdata;
   wire  [15:0] vendor_wdata;
   wire  [1:0]  vendor_addr;
   wire         vendor_wr, phy_reset_active, loop_back_enable, speed_100_select;
   wire         autoneg_enable, power_down, media_interface_disable, autoneg_restart;
   wire         full_duplex_select, collision_test_enable;
   wire  [7:0]  ctl = {loop_back_enable, speed_100_select, autoneg_enable, power_down,
                       media_interface_disable, autoneg_restart, full_duplex_select,
                       collision_test_enable};
   integer      err_total = 0, samples_checked = 0, i, vw_cnt = 0;
   logic [15:0] q, vw_data;
   logic [1:0]  vw_addr;
   pmrb_phy_mgmt_register_bank #(
      .ID_HIGH   (ID_HI_TB),
      .ID_OUI_LO (ID_OUI_TB),
      .ID_PART   (ID_PART_TB),
      .ID_REV    (ID_REV_TB)
   ) u_pmrb_phy_mgmt_register_bank (.*);
   always #12.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (vendor_wr === 1'b1) begin
         vw_cnt <= vw_cnt + 1;
         vw_addr <= vendor_addr;
         vw_data <= vendor_wdata;
      end
   end
   task chk(input [31:0] seen, input [31:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task end_sim;
      if (err_total == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task put(input [4:0] idx, input cmd, input [15:0] d);
      reg_wdata = {d, 5'h00, idx, cmd, 1'b1, 4'h0};
      reg_wr = 1'b1;
      @(negedge sys_clk);
      reg_wr = 1'b0;
   endtask
   // polls the start bit; a hung access ends the run rather than the wait
   task fin(output [15:0] r);
      integer n;
      n = 0;
      chk(reg_rdata[4], 1'b1);
      while (reg_rdata[4] !== 1'b0) begin
         @(negedge sys_clk);
         n = n + 1;
         if (n > 20) begin
            err_total = err_total + 1;
            end_sim;
         end
      end
      r = reg_rdata[31:16];
      reg_rd = 1'b1;
      @(negedge sys_clk);
      reg_rd = 1'b0;
   endtask
   task acc(input [4:0] idx, input cmd, input [15:0] d);
      put(idx, cmd, d);
      fin(q);
   endtask
   task rd(input [4:0] idx, input [15:0] exp);
      acc(idx, RD, 16'h0);
      chk(q, exp);
   endtask
   initial begin
      repeat (8) @(negedge sys_clk);
      rst_n = 1'b1;
      chk(ctl, 8'h60);
      rd(5'h00, 16'h3000);
      rd(5'h01, 16'h7809);
      rd(5'h02, ID_HI_TB);
      acc(5'h03, ~RD, 16'hffff);
      rd(5'h03, {ID_OUI_TB, ID_PART_TB, ID_REV_TB});
      for (i = 7; i < 15; i = i + 1) begin
         if (i != 9) begin
            acc(5'h00, ~RD, 16'h007f | (16'h1 << i));
            rd(5'h00, 16'h1 << i);
            chk(ctl, 8'h1 << (i - 7));
         end
      end
      acc(5'h00, ~RD, 16'h1200);
      chk(autoneg_restart, 1'b1);
      rd(5'h00, 16'h1200);
      repeat (20) @(negedge sys_clk);
      rd(5'h00, 16'h1000);
      acc(5'h00, ~RD, 16'hc100);
      chk(phy_reset_active, 1'b1);
      repeat (20) @(negedge sys_clk);
      rd(5'h00, 16'h3000);
      put(5'h00, RD, 16'h0);
      @(negedge sys_clk);
      put(5'h02, ~RD, 16'hbeef);
      fin(q);
      chk(q, 16'h3000);
      chk(reg_rdata[10:5], {5'h00, RD});
      acc(5'h13, ~RD, 16'ha5c3);
      chk({vw_addr, vw_data}, {2'h3, 16'ha5c3});
      rd(5'h11, 16'h1234);
      rd(5'h04, 16'h05e1);
      rd(5'h05, 16'h0041);
      acc(5'h14, ~RD, 16'hffff);
      rd(5'h14, 16'h0000);
      chk(vw_cnt, 1);
      reg_addr = 8'h18;
      @(negedge sys_clk);
      chk(reg_rdata, 32'h0);
      reg_addr = 8'h1c;
      link_live = 1'b1;
      rd(5'h01, 16'h7809);
      rd(5'h01, 16'h780d);
      link_live = 1'b0;
      @(negedge sys_clk);
      link_live = 1'b1;
      rd(5'h01, 16'h7809);
      for (i = 0; i < 3; i = i + 1) begin
         {jabber_live, vendor_irq_detect, partner_remote_fault} = 3'h1 << i;
         repeat (2) @(negedge sys_clk);
         {jabber_live, vendor_irq_detect, partner_remote_fault} = 3'h0;
         rd(5'h01, (i == 2) ? 16'h780f : 16'h781d);
         rd(5'h01, 16'h780d);
      end
      autoneg_done = 1'b1;
      rd(5'h01, 16'h782d);
      // a mid-run reset must drop the control word and the latched link bit
      acc(5'h00, ~RD, 16'h4100);
      chk(ctl, 8'h82);
      rst_n = 1'b0;
      repeat (2) @(negedge sys_clk);
      rst_n = 1'b1;
      chk(ctl, 8'h60);
      rd(5'h00, 16'h3000);
      rd(5'h01, 16'h7829);
      end_sim;
   end
endmodule // pmrb_phy_mgmt_register_bank_bench
